// ==== pkg/sas_pkg.sv ====
// Purpose: Constants and types for the successive-approximation converter sequencer.
// Assumes: 100 MHz clock, plain register port, one external converter core.
// Notes:   Functional notes follow.
// Functional notes
// - Enable bit 15 runs the module; cleared holds it inactive.
// - Stop-in-idle bit 13 suspends operation while chip idles.
// - Codes 111/110 left-justify into top ten bits of 32; 111 signed.
// - Code 100 right-justifies zero filled; 101 sign extends.
// - 16-bit codes zero upper half; 000 right, 010 left, 011 signed left.
// - Raw results stored; formatting applied when read.
// - Results go into a sixteen-entry buffer that software reads.
// - Trigger 000 converts when software clears sample-active.
// - Triggers 001 pin edge, 010 timer three match, 011 charge-time unit.
// - Trigger 111 uses internal counter; 100 to 110 reserved.
// - With auto-sample, hardware sets sample-active itself.
// - Other triggers: hardware clears sample-active when conversion starts.
// - Completion flag bit 0 set by hardware when conversion finishes.
// - Software clears completion flag with zero; ongoing conversion undisturbed.
// - Hardware clears completion flag when a new conversion begins.
// - Scan mode converts selected channels one after another.
// - Multiplexer alternates between two input selections per conversion.
// - Channel numbers address sixteen inputs, zero to fifteen.
package sas_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_CHAN  = 8'h04;
    localparam logic [7:0] OFF_SCAN  = 8'h08;
    localparam logic [7:0] OFF_STAT  = 8'h0c;
    localparam logic [7:0] OFF_BUF   = 8'h40;
    localparam int unsigned BIT_ON   = 15;
    localparam int unsigned BIT_IDLE = 13;
    localparam int unsigned BIT_FMT  = 8;
    localparam int unsigned BIT_TRIG = 5;
    localparam int unsigned BIT_CLRA = 4;
    localparam int unsigned BIT_AUTO = 2;
    localparam int unsigned BIT_SAMPLE_ACTIVE = 1;
    localparam int unsigned BIT_DONE = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_a7f7;
    localparam int unsigned DEPTH      = 16;
    // Auto-convert sample time
    localparam int unsigned SAMPLE_NS     = 100;
    localparam int unsigned CLK_NS        = 10;
    localparam int unsigned SAMPLE_CYCLES = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] TRIG_SOFT  = 3'h0;
    localparam logic [2:0] TRIG_PIN   = 3'h1;
    localparam logic [2:0] TRIG_TIMER = 3'h2;
    localparam logic [2:0] TRIG_CHARGE_TIME_MEASURE_UNIT  = 3'h3;
    localparam logic [2:0] TRIG_AUTO  = 3'h7;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sas_state_type;
    // Converter core handshake
    typedef struct packed {
        logic       start;
        logic [3:0] channel;
    } sas_conv_req_type;
    typedef struct packed {
        logic       done;
        logic [9:0] result;
    } sas_conv_rsp_type;
endpackage

// ==== hw/sas_sequencer.sv ====
// Purpose: Sampling, trigger, scan, buffer and read formatting for a 10-bit converter.
// Assumes: Converter core answers start with a done pulse and a raw result.
// Notes:   Trigger inputs from pins pass two flip-flops before use.
`timescale 1ns/10ps
module sas_sequencer (
    // Clock, reset, enable
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic                         clk_en,
    input  wire logic                         chip_idle,
    // Register port
    input  wire logic [sas_pkg::ADDR_W-1:0]   addr,
    input  wire logic [31:0]                  wdata,
    input  wire logic                         wr,
    input  wire logic                         rd,
    output logic [31:0]                       rdata,
    // Trigger sources
    input  wire logic                         external_interrupt_zero_pin,
    input  wire logic                         timer3_match,
    input  wire logic                         charge_time_measure_unit,
    // Converter core
    output sas_pkg::sas_conv_req_type         conv_req,
    input  wire sas_pkg::sas_conv_rsp_type    conv_rsp
);
    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [31:0] ctrl;
    logic [15:0] chan_sel;
    logic [15:0] scan_sel;
    logic [9:0]  buffer [sas_pkg::DEPTH];
    logic [3:0]  wr_ptr;
    logic [3:0]  scan_idx;
    logic        alt_set;
    logic [7:0]  sample_active_cnt;
    logic [2:0]  pin_sync;
    logic [1:0]  tmr_sync;
    logic [1:0]  ctm_sync;
    logic        tmr_q;
    logic        ctm_q;
    logic        trigger;
    logic        run;
    logic        conv_start;
    logic        busy;
    sas_pkg::sas_state_type state;

    // Release reset through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Format a raw result for reading
    function automatic logic [31:0] fmt(input logic [2:0] code, input logic [9:0] d);
        logic [31:0] r;
        r = 32'h0;
        unique case (code)
            3'h7: r = {~d[9], d[8:0], 22'h0};       // Signed fraction, 32
            3'h6: r = {d, 22'h0};
            3'h5: r = {{22{~d[9]}}, ~d[9], d[8:0]};
            3'h4: r = {22'h0, d};
            3'h3: r = {16'h0, ~d[9], d[8:0], 6'h0};
            3'h2: r = {16'h0, d, 6'h0};
            default: r = {22'h0, d};                // Code 000, and unlisted 001
        endcase
        return r;
    endfunction

    // Pin-side trigger inputs are asynchronous; sync before edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync <= 3'h0;
            tmr_sync <= 2'h0;
            ctm_sync <= 2'h0;
            tmr_q    <= 1'b0;
            ctm_q    <= 1'b0;
        end else if (clk_en) begin
            pin_sync <= {pin_sync[1:0], external_interrupt_zero_pin};
            tmr_sync <= {tmr_sync[0], timer3_match};
            ctm_sync <= {ctm_sync[0], charge_time_measure_unit};
            tmr_q    <= tmr_sync[1];
            ctm_q    <= ctm_sync[1];
        end
    end

    // Module runs when enabled and not stopped by idle
    assign run = ctrl[sas_pkg::BIT_ON]
               && !(ctrl[sas_pkg::BIT_IDLE] && chip_idle);

    // Trigger selection; reserved codes never fire
    always_comb begin
        trigger = 1'b0;
        unique case (ctrl[sas_pkg::BIT_TRIG +: 3])
            sas_pkg::TRIG_PIN:   trigger = pin_sync[1] && !pin_sync[2];
            sas_pkg::TRIG_TIMER: trigger = tmr_sync[1] && !tmr_q;
            sas_pkg::TRIG_CHARGE_TIME_MEASURE_UNIT:  trigger = ctm_sync[1] && !ctm_q;
            sas_pkg::TRIG_AUTO:  trigger = sample_active_cnt == 8'(sas_pkg::SAMPLE_CYCLES);
            default:             trigger = 1'b0;
        endcase
    end

    // Software drops sample-active under trigger 000 to convert
    logic sw_end;
    assign sw_end = wr && addr == sas_pkg::OFF_CTRL && !wdata[sas_pkg::BIT_SAMPLE_ACTIVE]
                  && ctrl[sas_pkg::BIT_SAMPLE_ACTIVE]
                  && ctrl[sas_pkg::BIT_TRIG +: 3] == sas_pkg::TRIG_SOFT;
    assign conv_start = run && state == sas_pkg::ST_SAMPLE;
    assign busy = state == sas_pkg::ST_CONVERT;

    // Sampling/conversion sequence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= sas_pkg::ST_IDLE;
            sample_active_cnt <= 8'h0;
            conv_req <= '0;
        end else if (clk_en) begin
            conv_req.start <= 1'b0;
            if (!run) begin
                state    <= sas_pkg::ST_IDLE;
                sample_active_cnt <= 8'h0;
            end else begin
                unique case (state)
                    sas_pkg::ST_IDLE: begin
                        sample_active_cnt <= 8'h0;
                        if (ctrl[sas_pkg::BIT_SAMPLE_ACTIVE] || ctrl[sas_pkg::BIT_AUTO]) begin
                            state <= sas_pkg::ST_SAMPLE;
                        end
                    end
                    sas_pkg::ST_SAMPLE: begin
                        sample_active_cnt <= sample_active_cnt + 8'h1;
                        if (trigger || sw_end) begin
                            state            <= sas_pkg::ST_CONVERT;
                            conv_req.start   <= 1'b1;
                            conv_req.channel <= ctrl[sas_pkg::BIT_CLRA] ? chan_sel[3:0]
                                              : (scan_sel != 16'h0 ? scan_idx
                                              : (alt_set ? chan_sel[11:8] : chan_sel[3:0]));
                        end
                    end
                    sas_pkg::ST_CONVERT: begin
                        sample_active_cnt <= 8'h0;
                        if (conv_rsp.done) begin
                            state <= ctrl[sas_pkg::BIT_SAMPLE_ACTIVE] ? sas_pkg::ST_SAMPLE
                                                             : sas_pkg::ST_IDLE;
                        end
                    end
                    default: state <= sas_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Scan through selected channels and alternate input sets
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_idx <= 4'h0;
            alt_set  <= 1'b0;
        end else if (clk_en && busy && conv_rsp.done) begin
            alt_set <= chan_sel[15] ? !alt_set : 1'b0;
            for (int i = 1; i <= 16; i++) begin
                if (scan_sel[4'(scan_idx + 4'(i))] && i <= 16) begin
                    scan_idx <= 4'(scan_idx + 4'(i));
                    break;
                end
            end
        end
    end

    // Advance the write pointer, wrapping after the last entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 4'h0;
        end else if (clk_en && busy && conv_rsp.done) begin
            wr_ptr <= wr_ptr + 4'h1;
        end
    end

    // Store raw results; no reset, so the array maps onto plain storage
    always_ff @(posedge clk) begin
        if (clk_en && busy && conv_rsp.done) begin
            buffer[wr_ptr] <= conv_rsp.result;
        end
    end

    // Control register: software fields plus hardware-owned sample/done bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= sas_pkg::CTRL_RESET;
            chan_sel <= 16'h0;
            scan_sel <= 16'h0;
        end else if (clk_en) begin
            if (wr && addr == sas_pkg::OFF_CTRL) begin
                ctrl[15:2] <= wdata[15:2] & sas_pkg::CTRL_MASK[15:2];
                ctrl[sas_pkg::BIT_SAMPLE_ACTIVE] <= wdata[sas_pkg::BIT_SAMPLE_ACTIVE];
                if (!wdata[sas_pkg::BIT_DONE]) begin
                    ctrl[sas_pkg::BIT_DONE] <= 1'b0;                  // Write one ignored
                end
            end
            if (wr && addr == sas_pkg::OFF_CHAN) begin
                chan_sel <= wdata[15:0];
            end
            if (wr && addr == sas_pkg::OFF_SCAN) begin
                scan_sel <= wdata[15:0];
            end
            // Auto-sample re-arms sampling whenever the running sequencer rests in idle
            if (run && ctrl[sas_pkg::BIT_AUTO] && state == sas_pkg::ST_IDLE) begin
                ctrl[sas_pkg::BIT_SAMPLE_ACTIVE] <= 1'b1;
            end
            // Hardware events win over a same-cycle software write
            if (conv_start && (trigger || sw_end)) begin
                ctrl[sas_pkg::BIT_SAMPLE_ACTIVE] <= 1'b0;
                ctrl[sas_pkg::BIT_DONE] <= 1'b0;
            end
            if (run && busy && conv_rsp.done) begin
                ctrl[sas_pkg::BIT_DONE] <= 1'b1;
                if (ctrl[sas_pkg::BIT_AUTO]) begin
                    ctrl[sas_pkg::BIT_SAMPLE_ACTIVE] <= 1'b1;
                end
            end
        end
    end

    // Read data one cycle after the strobe; formatting applied here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else if (clk_en) begin
            rdata <= 32'h0;
            if (rd) begin
                if (addr == sas_pkg::OFF_CTRL) begin
                    rdata <= ctrl;
                end else if (addr == sas_pkg::OFF_CHAN) begin
                    rdata <= {16'h0, chan_sel};
                end else if (addr == sas_pkg::OFF_SCAN) begin
                    rdata <= {16'h0, scan_sel};
                end else if (addr == sas_pkg::OFF_STAT) begin
                    rdata <= {24'h0, 2'(state), 2'h0, wr_ptr};
                end else if (addr[7:6] == 2'h1 && addr[1:0] == 2'h0) begin
                    rdata <= fmt(ctrl[sas_pkg::BIT_FMT +: 3], buffer[addr[5:2]]);
                end
            end
        end
    end

    // Checks below watch only what this block drives.
    // All of them use the internal reset copy, so release glitches are masked.

    // Done must rise one edge after the core reports completion
    done_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && run && busy && conv_rsp.done |=> ctrl[sas_pkg::BIT_DONE])
        else $error("completion flag not set");

    // A start pulse and the done clear share one edge
    start_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        conv_req.start |-> !ctrl[sas_pkg::BIT_DONE])
        else $error("completion flag not cleared at start");

    // Clearing the enable parks the sequence at once
    off_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl[sas_pkg::BIT_ON] && clk_en |=> state == sas_pkg::ST_IDLE)
        else $error("disabled module not idle");

    // Stop-in-idle must block new starts
    idle_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        chip_idle && ctrl[sas_pkg::BIT_IDLE] |=> !conv_req.start)
        else $error("start while stopped in idle");

    // Pointer steps once per stored result
    ptr_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && busy && conv_rsp.done |=> wr_ptr == $past(wr_ptr) + 4'h1)
        else $error("buffer pointer did not advance");

    // Trigger-ended sampling drops sample-active by hardware
    hw_sample_active_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        conv_req.start && ctrl[sas_pkg::BIT_TRIG +: 3] != sas_pkg::TRIG_SOFT
        |-> !ctrl[sas_pkg::BIT_SAMPLE_ACTIVE] || ctrl[sas_pkg::BIT_AUTO])
        else $error("sample-active not cleared by trigger");

    // Reserved trigger codes must stay silent
    reserved_trig_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl[7] && ctrl[6:5] != 2'h3 |-> !trigger)
        else $error("reserved trigger fired");

    // Plain integer layout keeps the upper bits clear
    fmt_int_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr == sas_pkg::OFF_BUF && ctrl[10:8] == 3'h4
        |=> rdata[31:10] == 22'h0)
        else $error("integer format upper bits not zero");

    // The core counts on a single-cycle start; a long one would restart it
    start_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        conv_req.start && clk_en |=> !conv_req.start)
        else $error("start pulse longer than one cycle");

    // Read data stands only in the cycle after the strobe
    rd_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !rd |=> rdata == 32'h0)
        else $error("read data not cleared");

    // Unimplemented control bits 31 to 16 and 14 never hold a one
    reserved_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en |-> ctrl[31:16] == 16'h0 && !ctrl[14])
        else $error("unimplemented control bit set");

    // Software clearing sample-active launches a conversion
    soft_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && conv_start && sw_end |=> busy && conv_req.start)
        else $error("software end did not start conversion");

    // Hardware clear beats a same-cycle software write
    hw_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && conv_start && trigger |=> !ctrl[sas_pkg::BIT_SAMPLE_ACTIVE])
        else $error("trigger left sample-active set");

    // Auto-sample must not wait for software
    auto_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && run && ctrl[sas_pkg::BIT_AUTO] && state == sas_pkg::ST_IDLE
        |=> ctrl[sas_pkg::BIT_SAMPLE_ACTIVE])
        else $error("auto-sample did not set sample-active");

    // Alternate mode flips the input set after each result
    alt_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && busy && conv_rsp.done && chan_sel[15] |=> alt_set != $past(alt_set))
        else $error("input set did not alternate");

    // The raw result lands in the entry the pointer named
    buf_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && busy && conv_rsp.done
        |=> buffer[$past(wr_ptr)] == $past(conv_rsp.result))
        else $error("result not stored in buffer");

    // While the module runs, nothing but a completion may end a conversion
    conv_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && run && busy && !conv_rsp.done |=> busy)
        else $error("conversion disturbed");

    // A stopped module never asks the core for work
    off_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !run |=> !conv_req.start)
        else $error("start while module not running");

    // Fractional 32-bit layouts leave the low bits clear
    fmt_frac_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr == sas_pkg::OFF_BUF && ctrl[10:9] == 2'h3
        |=> rdata[21:0] == 22'h0)
        else $error("fractional format low bits not zero");

    // The 16-bit layouts read zero in the upper half
    fmt_half_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd && addr == sas_pkg::OFF_BUF && !ctrl[10]
        |=> rdata[31:16] == 16'h0)
        else $error("16-bit format upper half not zero");

    // Pointer holds still between results
    ptr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !(busy && conv_rsp.done) |=> wr_ptr == $past(wr_ptr))
        else $error("buffer pointer moved without a result");

    // Writing one to the flag must not set it
    done_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && wr && addr == sas_pkg::OFF_CTRL && wdata[sas_pkg::BIT_DONE]
        && !ctrl[sas_pkg::BIT_DONE] && !(busy && conv_rsp.done)
        |=> !ctrl[sas_pkg::BIT_DONE])
        else $error("software set the completion flag");
endmodule

// ==== testbench/sas_conv_model.sv ====
// Purpose: Behavioural converter core that answers each start pulse.
// Assumes: Fixed latency; result value supplied by the bench.
// Notes:   Result bus shows the inverse of the last result outside done.
`timescale 1ns/10ps
module sas_conv_model #(
    parameter int LAT = 12
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Converter handshake
    input  wire sas_pkg::sas_conv_req_type conv_req,
    input  wire logic [9:0]                value,
    output sas_pkg::sas_conv_rsp_type      conv_rsp
);
    logic [9:0] last;
    int         cnt;

    // Count down from each start; stale data is inverted so it never looks valid
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt      <= 0;
            last     <= 10'h000;
            conv_rsp <= '0;
        end else begin
            conv_rsp.done   <= 1'b0;
            conv_rsp.result <= ~last;
            if (conv_req.start) begin
                cnt <= LAT;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else if (cnt == 1) begin
                cnt             <= 0;
                conv_rsp.done   <= 1'b1;
                conv_rsp.result <= value;
                last            <= value;
            end
        end
    end
endmodule

// ==== testbench/test_sar_adc_sequencer.sv ====
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Start pulses are logged to check triggers and channel order.
`timescale 1ns/10ps
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_sar_adc_sequencer;
    logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, chip_idle = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic wr = 1'b0, rd = 1'b0, pin = 1'b0, tmr = 1'b0, ctm = 1'b0;
    logic [9:0] value = 10'h000;
    sas_pkg::sas_conv_req_type conv_req;
    sas_pkg::sas_conv_rsp_type conv_rsp;
    logic [3:0] chans[$];
    int checks = 0, miscompares = 0, starts = 0, n;

    always #5 clk = ~clk;

    sas_sequencer uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .chip_idle(chip_idle), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .external_interrupt_zero_pin(pin), .timer3_match(tmr),
        .charge_time_measure_unit(ctm), .conv_req(conv_req), .conv_rsp(conv_rsp));
    sas_conv_model core (.clk(clk), .reset_n(reset_n), .conv_req(conv_req),
        .value(value), .conv_rsp(conv_rsp));

    // Log every start pulse with its channel
    always @(posedge clk) begin
        if (conv_req.start === 1'b1) begin
            chans.push_back(conv_req.channel);
            starts++;
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Poll the completion flag; bounded so a stuck flag cannot hang the run
    task automatic wait_done();
        for (int i = 0; i < 40; i++) begin
            rd_reg(sas_pkg::OFF_CTRL, d);
            if (d[0] === 1'b1) break;
        end
    endtask

    task automatic idle_cycles(input int c);
        repeat (c) @(posedge clk);
    endtask

    // Expected read word for a format code and raw result
    function automatic logic [31:0] fmt(input logic [2:0] f, input logic [9:0] r);
        case (f)
            // Signed codes read two's complement: mid-scale is zero
            3'h2:       return {16'h0000, r, 6'h00};
            3'h3:       return {16'h0000, ~r[9], r[8:0], 6'h00};
            3'h5:       return {{23{~r[9]}}, r[8:0]};
            3'h6:       return {r, 22'h000000};
            3'h7:       return {~r[9], r[8:0], 22'h000000};
            default:    return {22'h000000, r};
        endcase
    endfunction

    task automatic complete_run();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200us;
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        idle_cycles(3);
        rd_reg(sas_pkg::OFF_CTRL, d); `CMP(d, 32'h00000000)
        rd_reg(8'h30, d); `CMP(d, 32'h00000000)
        wr_reg(sas_pkg::OFF_CTRL, 32'h0001);
        rd_reg(sas_pkg::OFF_CTRL, d); `CMP(d, 32'h00000000)
        // Software-timed conversion, then a second one with the flag left set
        value <= 10'h2a5;
        wr_reg(sas_pkg::OFF_CTRL, 32'h8002);
        wr_reg(sas_pkg::OFF_CTRL, 32'h8000);
        wait_done(); `CMP(d, 32'h00008001)
        `CMP(starts, 1)
        value <= 10'h15a;
        wr_reg(sas_pkg::OFF_CTRL, 32'h8003);
        rd_reg(sas_pkg::OFF_CTRL, d); `CMP(d, 32'h00008003)
        wr_reg(sas_pkg::OFF_CTRL, 32'h8001);
        rd_reg(sas_pkg::OFF_CTRL, d); `CMP(d, 32'h00008000)
        wait_done(); `CMP(d, 32'h00008001)
        // Every format applied at read time to the same stored entries
        for (int f = 0; f < 8; f++) begin
            wr_reg(sas_pkg::OFF_CTRL, 32'h8000 | (f << 8));
            rd_reg(sas_pkg::OFF_BUF, d); `CMP(d, fmt(f, 10'h2a5))
            rd_reg(8'h44, d); `CMP(d, fmt(f, 10'h15a))
        end
        // External triggers end sampling and clear the sample bit
        for (int c = 1; c < 4; c++) begin
            wr_reg(sas_pkg::OFF_CTRL, 32'h8002 | (c << 5));
            n = starts;
            pin <= (c == 1);
            tmr <= (c == 2);
            ctm <= (c == 3);
            idle_cycles(4);
            {pin, tmr, ctm} <= 3'b000;
            wait_done(); `CMP(d, 32'h8001 | (c << 5))
            `CMP(starts, n + 1)
        end
        // Reserved codes, disabled module and idle stop never start
        n = starts;
        for (int c = 4; c < 7; c++) begin
            wr_reg(sas_pkg::OFF_CTRL, 32'h8002 | (c << 5));
            {pin, tmr, ctm} <= 3'b111;
            idle_cycles(4);
            {pin, tmr, ctm} <= 3'b000;
            wr_reg(sas_pkg::OFF_CTRL, 32'h8000 | (c << 5));
            idle_cycles(20);
        end
        `CMP(starts, n)
        wr_reg(sas_pkg::OFF_CTRL, 32'h0002);
        idle_cycles(1);
        wr_reg(sas_pkg::OFF_CTRL, 32'h0000);
        idle_cycles(20); `CMP(starts, n)
        chip_idle <= 1'b1;
        wr_reg(sas_pkg::OFF_CTRL, 32'ha002);
        wr_reg(sas_pkg::OFF_CTRL, 32'ha000);
        idle_cycles(20); `CMP(starts, n)
        wr_reg(sas_pkg::OFF_CTRL, 32'h0000);
        wr_reg(sas_pkg::OFF_CTRL, 32'h8002);
        wr_reg(sas_pkg::OFF_CTRL, 32'h8000);
        wait_done(); `CMP(starts, n + 1)
        chip_idle <= 1'b0;
        // Auto sample and convert, alternating between two channel sets
        wr_reg(sas_pkg::OFF_CHAN, 32'h8905);
        chans.delete();
        wr_reg(sas_pkg::OFF_CTRL, 32'h80e4);
        for (int i = 0; i < 600 && chans.size() < 4; i++) idle_cycles(1);
        wr_reg(sas_pkg::OFF_CTRL, 32'h0000);
        `CMP(chans.size() >= 4, 1'b1)
        for (int k = 0; k < 3 && k + 1 < chans.size(); k++) begin
            `CMP(chans[k] + chans[k + 1], 5'd14)
        end
        // Scan over inputs 0, 2 and 15
        wr_reg(sas_pkg::OFF_CHAN, 32'h0000);
        wr_reg(sas_pkg::OFF_SCAN, 32'h8005);
        idle_cycles(30);
        chans.delete();
        wr_reg(sas_pkg::OFF_CTRL, 32'h80e4);
        for (int i = 0; i < 600 && chans.size() < 3; i++) idle_cycles(1);
        wr_reg(sas_pkg::OFF_CTRL, 32'h0000);
        `CMP(chans.size() >= 3, 1'b1)
        for (int k = 0; k < 3 && k < chans.size(); k++) begin
            `CMP(16'h8005 >> chans[k] & 16'h1, 16'h1)
        end
        complete_run();
    end
endmodule
